// file: logic/adcs_sequencer.sv
// Function
// - Every finished 8-bit unsigned code lands in the read-only result register
// - Three low control bits choose analog input n, values 0 to 7
// - After power-on wait about 30 us, then convert continuously without trigger
// - Each conversion takes 64 clocks, first 32 of them sampling
// - Conversion end sets bit 7 complete flag with result present, no interrupt
// - Any control write aborts conversion, clears flag, restarts with new settings
// - Reading the result register clears the complete flag
// - Input at or above high reference gives FFh, at or below low gives 00h
// - Codes are monotonic in the input
// - Code follows 255 times input over reference span
// - Bit 5 powers converter on when set, off when clear
// - Wait low-power mode leaves the converter untouched
// - Halt disables the converter; wake-up needs fresh stabilisation
// - Bit 4 of the control register always reads zero
`timescale 1ns/1ps
module adcs_sequencer #(
  parameter int STAB_COUNT = adcs_pkg::STAB_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [adcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic haltMode,
  input wire logic waitMode,
  input wire logic compHigher,
  output logic [adcs_pkg::CHAN_W-1:0] muxSelect,
  output logic sampleEnable,
  output logic [7:0] dacCode,
  output logic analogPowerOn
);
  logic rstSync1_r;
  logic rstSync2_r;
  logic rstN;
  logic compSync1_r;
  logic compSync2_r;
  logic haltSync1_r;
  logic haltSync2_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end
  assign rstN = rstSync2_r;

  // The comparator and halt come from the analog/clock side, so synchronise
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      compSync1_r <= 1'b0;
      compSync2_r <= 1'b0;
    end else begin
      compSync1_r <= compHigher;
      compSync2_r <= compSync1_r;
    end
  end

  // Halt is a level; two flops are enough since only its steady value matters
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      haltSync1_r <= 1'b0;
      haltSync2_r <= 1'b0;
    end else begin
      haltSync1_r <= haltMode;
      haltSync2_r <= haltSync1_r;
    end
  end

  adcs_pkg::adcs_bus_type bus;
  assign bus.addr = regAddr;
  assign bus.wdata = regWdata;
  assign bus.wr = regWr;
  assign bus.rd = regRd;

  adcs_pkg::adcs_ctrl_type ctrl_r;
  adcs_pkg::adcs_ctrl_type ctrl_nxt;
  logic [7:0] result_r;
  logic [7:0] result_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] sar_r;
  logic [7:0] sar_nxt;
  logic [2:0] bitIdx_r;
  logic [2:0] bitIdx_nxt;
  logic [12:0] stabCnt_r;
  logic [12:0] stabCnt_nxt;
  logic [5:0] phaseCnt_r;
  logic [5:0] phaseCnt_nxt;
  adcs_pkg::adcs_state_type state_r;
  adcs_pkg::adcs_state_type state_nxt;
  logic ctrlWrite;
  logic resultRead;
  logic convDone;
  logic powered;
  logic [7:0] trial;
  logic [7:0] bitMask;
  logic [7:0] bitMaskNxt;
  logic sampleOut_r;
  logic sampleOut_nxt;
  logic powerOut_r;
  logic powerOut_nxt;
  logic [7:0] dacOut_r;
  logic [7:0] dacOut_nxt;

  // One-hot mask of the bit under test, MSB first
  for (genvar b = 0; b < adcs_pkg::DATA_W; b++) begin : g_mask
    assign bitMask[b] = (bitIdx_r == 3'(adcs_pkg::DATA_W - 1 - b));
    assign bitMaskNxt[b] = (bitIdx_nxt == 3'(adcs_pkg::DATA_W - 1 - b));
  end

  assign ctrlWrite = bus.wr && (bus.addr == adcs_pkg::CTRL_OFFSET);
  assign resultRead = bus.rd && (bus.addr == adcs_pkg::RESULT_OFFSET);
  // Wait mode is deliberately not consulted anywhere
  assign powered = ctrl_r.powerOn && !haltSync2_r;

  // Trial code: keep decided bits, set the bit under test
  always_comb begin
    trial = sar_r | bitMask;
  end

  always_comb begin
    state_nxt = state_r;
    stabCnt_nxt = stabCnt_r;
    phaseCnt_nxt = phaseCnt_r;
    sar_nxt = sar_r;
    bitIdx_nxt = bitIdx_r;
    convDone = 1'b0;
    case (state_r)
      adcs_pkg::ST_OFF: begin
        if (powered) begin
          state_nxt = adcs_pkg::ST_STAB;
          stabCnt_nxt = '0;
        end
      end
      adcs_pkg::ST_STAB: begin
        if (stabCnt_r == 13'(STAB_COUNT - 1)) begin
          state_nxt = adcs_pkg::ST_SAMPLE;
          phaseCnt_nxt = '0;
        end else begin
          stabCnt_nxt = stabCnt_r + 13'h1;
        end
      end
      adcs_pkg::ST_SAMPLE: begin
        phaseCnt_nxt = phaseCnt_r + 6'h1;
        if (phaseCnt_r == 6'(adcs_pkg::SAMPLE_CYCLES - 1)) begin
          state_nxt = adcs_pkg::ST_APPROX;
          sar_nxt = adcs_pkg::CODE_ZERO;
          bitIdx_nxt = '0;
        end
      end
      adcs_pkg::ST_APPROX: begin
        phaseCnt_nxt = phaseCnt_r + 6'h1;
        // Keep a trial bit only when the input is at or above its level, so
        // a full-scale input saturates at FFh and ground gives 00h
        if (phaseCnt_r[1:0] == 2'(adcs_pkg::BIT_CYCLES - 1)) begin
          sar_nxt = compSync2_r ? trial : sar_r;
          bitIdx_nxt = bitIdx_r + 3'h1;
        end
        if (phaseCnt_r == 6'(adcs_pkg::CONV_CYCLES - 1)) begin
          convDone = 1'b1;
          state_nxt = adcs_pkg::ST_SAMPLE;
          phaseCnt_nxt = '0;
        end
      end
      default: state_nxt = adcs_pkg::ST_OFF;
    endcase
    // Abort and restart from sampling; stabilisation is not repeated
    if (ctrlWrite && state_r != adcs_pkg::ST_OFF && state_r != adcs_pkg::ST_STAB) begin
      state_nxt = adcs_pkg::ST_SAMPLE;
      phaseCnt_nxt = '0;
      convDone = 1'b0;
    end
    if (!powered) begin
      state_nxt = adcs_pkg::ST_OFF;
      convDone = 1'b0;
    end
  end

  // Final bit decided on the last cycle, so fold it into the stored code
  always_comb begin
    ctrl_nxt = ctrl_r;
    result_nxt = result_r;
    if (convDone) begin
      result_nxt = compSync2_r ? trial : sar_r;
    end
    if (resultRead) begin
      ctrl_nxt.complete = 1'b0;
    end
    if (ctrlWrite) begin
      ctrl_nxt.powerOn = bus.wdata[adcs_pkg::POWER_BIT];
      ctrl_nxt.chanSel = bus.wdata[adcs_pkg::CHAN_LSB +: adcs_pkg::CHAN_W];
      ctrl_nxt.complete = 1'b0;
    end
    // Completion set wins over a same-cycle read clear
    if (convDone) begin
      ctrl_nxt.complete = 1'b1;
    end
  end

  // Read data stand for one cycle only; the idle value is zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (bus.rd) begin
      if (bus.addr == adcs_pkg::CTRL_OFFSET) begin
        rdata_nxt[adcs_pkg::COMPLETE_BIT] = ctrl_r.complete;
        rdata_nxt[adcs_pkg::POWER_BIT] = ctrl_r.powerOn;
        rdata_nxt[adcs_pkg::ZERO_BIT] = 1'b0;
        rdata_nxt[adcs_pkg::CHAN_LSB +: adcs_pkg::CHAN_W] = ctrl_r.chanSel;
      end else if (bus.addr == adcs_pkg::RESULT_OFFSET) begin
        rdata_nxt = result_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // Outputs are registered from next values, so the analog side sees
  // glitch-free levels without an extra cycle of delay
  always_comb begin
    sampleOut_nxt = (state_nxt == adcs_pkg::ST_SAMPLE);
    powerOut_nxt = ctrl_nxt.powerOn && !haltSync1_r;
    dacOut_nxt = adcs_pkg::CODE_ZERO;
    if (state_nxt == adcs_pkg::ST_APPROX) begin
      dacOut_nxt = sar_nxt | bitMaskNxt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= adcs_pkg::ST_OFF;
      stabCnt_r <= '0;
      phaseCnt_r <= '0;
      sar_r <= adcs_pkg::CODE_ZERO;
      bitIdx_r <= '0;
    end else begin
      state_r <= state_nxt;
      stabCnt_r <= stabCnt_nxt;
      phaseCnt_r <= phaseCnt_nxt;
      sar_r <= sar_nxt;
      bitIdx_r <= bitIdx_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ctrl_r <= '0;
      result_r <= adcs_pkg::RESULT_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
      result_r <= result_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sampleOut_r <= 1'b0;
      powerOut_r <= 1'b0;
      dacOut_r <= adcs_pkg::CODE_ZERO;
    end else begin
      sampleOut_r <= sampleOut_nxt;
      powerOut_r <= powerOut_nxt;
      dacOut_r <= dacOut_nxt;
    end
  end

  assign regRdata = rdata_r;
  assign muxSelect = ctrl_r.chanSel;
  assign sampleEnable = sampleOut_r;
  assign dacCode = dacOut_r;
  // Equal to the internal powered term, one flop later from its next value
  assign analogPowerOn = powerOut_r;
endmodule

// file: logic/adcs_pkg.sv
package adcs_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] RESULT_OFFSET = 4'h4;
  localparam int DATA_W = 8;
  localparam int COMPLETE_BIT = 7;
  localparam int POWER_BIT = 5;
  localparam int ZERO_BIT = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  localparam int NUM_CHAN = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h6F;
  localparam logic [7:0] CODE_FULL = 8'hFF;
  localparam logic [7:0] CODE_ZERO = 8'h00;
  localparam int CLK_MHZ = 250;
  localparam int STAB_TIME_US = 30;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
  localparam int CONV_CYCLES = 64;
  localparam int SAMPLE_HALF_CYCLES = 63;
  localparam int SAMPLE_CYCLES = (SAMPLE_HALF_CYCLES + 1) / 2;
  localparam int BIT_CYCLES = (CONV_CYCLES - SAMPLE_CYCLES) / DATA_W;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_STAB,
    ST_SAMPLE,
    ST_APPROX
  } adcs_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } adcs_bus_type;

  typedef struct packed {
    logic complete;
    logic powerOn;
    logic [CHAN_W-1:0] chanSel;
  } adcs_ctrl_type;
endpackage

// file: bench/adcs_sequencer_props.sv
`timescale 1ns/1ps
module adcs_sequencer_props #(
  parameter int STAB_COUNT = adcs_pkg::STAB_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [adcs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic haltMode,
  input wire logic [adcs_pkg::CHAN_W-1:0] muxSelect,
  input wire logic sampleEnable,
  input wire logic [7:0] dacCode,
  input wire logic analogPowerOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int smpCnt_r;
  int stbCnt_r;
  // A control write restarts sampling; the count restarts on any write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      smpCnt_r <= 0;
      stbCnt_r <= 0;
    end else begin
      smpCnt_r <= (sampleEnable && !regWr) ? smpCnt_r + 1 : 0;
      stbCnt_r <= (analogPowerOn && !sampleEnable && dacCode == 8'h00) ? stbCnt_r + 1 : 0;
    end
  end
  a_read_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not idle");
  a_fixed_zero: assert property (regRd && regAddr == adcs_pkg::CTRL_OFFSET
    |=> (regRdata & 8'h58) == 8'h00) else $error("fixed bits not zero");
  a_chan_follow: assert property (regWr && regAddr == adcs_pkg::CTRL_OFFSET
    |=> {5'h00, muxSelect} == ($past(regWdata) & 8'h07)) else $error("channel wrong");
  a_power_follow: assert property (regWr && regAddr == 4'h0 && !haltMode
    |=> (analogPowerOn ? 8'h20 : 8'h00) == ($past(regWdata) & 8'h20)) else $error("power");
  a_sample_len: assert property ($fell(sampleEnable) |-> smpCnt_r == 32 || !analogPowerOn)
    else $error("sampling length wrong");
  a_approx_msb: assert property ($fell(sampleEnable) && analogPowerOn
    |-> (dacCode == 8'h80)[*4]) else $error("first trial wrong");
  a_stab_wait: assert property ($rose(sampleEnable) && $past(dacCode) == 8'h00
    |-> stbCnt_r == STAB_COUNT + 1) else $error("settling time wrong");
  a_halt_off: assert property (haltMode[*4] |-> !analogPowerOn && !sampleEnable)
    else $error("halt left converter on");
endmodule

bind adcs_sequencer adcs_sequencer_props #(.STAB_COUNT(STAB_COUNT)) i_props (
  .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .haltMode(haltMode), .muxSelect(muxSelect),
  .sampleEnable(sampleEnable), .dacCode(dacCode), .analogPowerOn(analogPowerOn));

// file: bench/test_adcs_sequencer.sv
`timescale 1ns/1ps
module test_adcs_sequencer;
  logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, haltMode = 1'b0, waitMode = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, dacCode, d;
  logic [2:0] muxSelect;
  logic sampleEnable, analogPowerOn, compHigher;
  logic [7:0] vin [8] = '{8'h00, 8'h01, 8'h5A, 8'h7F, 8'h80, 8'hA5, 8'hFE, 8'hFF};
  int n_mismatch = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  // Ideal comparator on the selected input
  assign compHigher = vin[muxSelect] >= dacCode;
  adcs_sequencer #(.STAB_COUNT(8)) i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .haltMode(haltMode), .waitMode(waitMode), .compHigher(compHigher),
    .muxSelect(muxSelect), .sampleEnable(sampleEnable), .dacCode(dacCode),
    .analogPowerOn(analogPowerOn));
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Polling keeps the result unread, so the flag is not disturbed
  task wait_done;
    for (int i = 0; i < 200; i++) begin
      rd(4'h0);
      if (d[7] === 1'b1) return;
    end
    $display("ERROR %0t no completion", $time);
    n_mismatch++;
    give_verdict;
  endtask
  task t_idle_regs;
    rd(4'h0);
    chk(d, 8'h00);
    wr(4'h4, 8'h55);
    rd(4'h4);
    chk(d, 8'h00);
    rd(4'h2);
    chk(d, 8'h00);
  endtask
  task t_channels;
    for (int c = 0; c < 8; c++) begin
      waitMode <= c[0];
      wr(4'h0, 8'h20 | 8'(c));
      wait_done;
      chk(d, 8'hA0 | 8'(c));
      rd(4'h4);
      chk(d, vin[c]);
      rd(4'h0);
      chk(d, 8'h20 | 8'(c));
    end
  endtask
  task t_abort_overwrite;
    // Abort inside sampling, never in the first approximation bit
    for (int i = 0; i < 200 && sampleEnable !== 1'b1; i++) @(posedge clk);
    if (sampleEnable !== 1'b1) begin
      $display("ERROR %0t no sampling", $time);
      n_mismatch++;
      give_verdict;
    end
    repeat (5) @(posedge clk);
    wr(4'h0, 8'hB6);
    rd(4'h0);
    chk(d, 8'h26);
    wait_done;
    rd(4'h4);
    chk(d, vin[6]);
    vin[6] <= 8'h33;
    repeat (150) @(posedge clk);
    rd(4'h4);
    chk(d, 8'h33);
  endtask
  task t_halt_off;
    haltMode <= 1'b1;
    repeat (6) @(posedge clk);
    chk({7'h00, analogPowerOn}, 8'h00);
    haltMode <= 1'b0;
    repeat (4) @(posedge clk);
    wait_done;
    rd(4'h4);
    chk(d, 8'h33);
    wr(4'h0, 8'h00);
    repeat (100) @(posedge clk);
    rd(4'h0);
    chk(d, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_idle_regs;
    t_channels;
    t_abort_overwrite;
    t_halt_off;
    give_verdict;
  end
endmodule
